// ==== hw/fsg_flash_section_write_guard.v ====
// What this block does
// - Flash pages of 512 bytes, byte/word writes.
// - Three consecutive regions: loader, program, parameter.
// - Refuse writes to the executing region.
// - From loader: flash halts CPU, EEPROM not.
// - From program: only parameter and EEPROM writes.
// - From parameter region: block all writes.
// - Region sizes from two fuses, 512-byte blocks.
// - Loader, then program, remainder is parameter region.
// - Loader fuse zero: whole flash is loader.
// - Program fuse zero: program region to end.
// - Program fuse not above loader: no program region.
// - Out-of-range fuse falls back to default.
// - Vectors at program start, or loader when selected.
// - Read lock blocks loader reads and fetches.
// - Read lock set from loader, effective after leaving.
// - Program and parameter write locks block updates.
`timescale 1ns/1ps
`default_nettype none
`include "fsg_defines.vh"
module fsg_flash_section_write_guard #(
  parameter ADDR_W = 16,
  parameter FUSE_W = 8,
  parameter FLASH_PAGES = 128,
  parameter HALT_CYCLES = 16
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Fuses, sampled continuously
  input wire [FUSE_W-1:0] loader_size_fuse,
  input wire [FUSE_W-1:0] program_size_fuse,
  // CPU fetch and data read
  input wire [ADDR_W-1:0] fetch_addr,
  input wire fetch_valid,
  input wire [ADDR_W-1:0] read_addr,
  input wire read_valid,
  // CPU self-programming write request
  input wire wr_req,
  input wire [ADDR_W-1:0] wr_addr,
  input wire wr_is_eeprom,
  input wire wr_len,
  // Control bits
  input wire vector_table_select,
  input wire loader_read_lock_set,
  input wire program_write_lock_set,
  input wire parameter_write_lock_set,
  // Grant, refusal and stall
  output reg flash_wr_en_r,
  output reg eeprom_wr_en_r,
  output reg wr_refused_r,
  output reg cpu_halt_r,
  output reg [ADDR_W-1:0] flash_wr_addr_r,
  output reg flash_wr_len_r,
  // Read protection
  output reg fetch_blocked_r,
  output reg read_blocked_r,
  // Status
  output reg [1:0] exec_region_r,
  output reg [ADDR_W-1:0] vector_base_r,
  output reg loader_read_lock_r,
  output reg program_write_lock_r,
  output reg parameter_write_lock_r
);
  localparam PAGE_W = ADDR_W - `FSG_PAGE_SHIFT;
  localparam CNT_W = 8;
  localparam [31:0] HALT_LAST_I = HALT_CYCLES - 1;
  localparam [CNT_W-1:0] HALT_LAST = HALT_LAST_I[CNT_W-1:0];
  localparam ST_IDLE = 1'b0;
  localparam ST_HALT = 1'b1;

  wire [PAGE_W:0] loader_end_pg;
  wire [PAGE_W:0] program_end_pg;
  reg state_r;
  reg state_nxt;
  reg [CNT_W-1:0] cnt_r;
  reg lock_armed_r;
  reg [1:0] wr_region;
  reg [1:0] fetch_region;
  reg [1:0] rd_region;
  reg allow;
  reg halt_needed;
  reg take_req;
  reg flash_grant;
  reg eeprom_grant;
  reg refuse;
  reg [CNT_W-1:0] cnt_nxt;
  reg [1:0] exec_region_nxt;
  reg [ADDR_W-1:0] vector_base_nxt;
  reg lock_armed_nxt;
  reg loader_read_lock_nxt;
  reg program_write_lock_nxt;
  reg parameter_write_lock_nxt;
  reg fetch_blocked_nxt;
  reg read_blocked_nxt;

  fsg_region_map #(
    .FUSE_W(FUSE_W),
    .PAGE_W(PAGE_W),
    .FLASH_PAGES(FLASH_PAGES)
  ) u_map (
    .clk(clk),
    .rst_n(rst_n),
    .loader_size_fuse(loader_size_fuse),
    .program_size_fuse(program_size_fuse),
    .loader_end_pg_r(loader_end_pg),
    .program_end_pg_r(program_end_pg)
  );

  // Region of an address; pages are the 512-byte units.
  function [1:0] region_of;
    input [ADDR_W-1:0] a;
    input [PAGE_W:0] le;
    input [PAGE_W:0] pe;
    reg [PAGE_W:0] pg;
    begin
      pg = {1'b0, a[ADDR_W-1:`FSG_PAGE_SHIFT]};
      if (pg < le)
        region_of = `FSG_REG_LOADER;
      else if (pg < pe)
        region_of = `FSG_REG_PROGRAM;
      else
        region_of = `FSG_REG_PARAM;
    end
  endfunction

  always @*
  begin
    wr_region = region_of(wr_addr, loader_end_pg, program_end_pg);
    fetch_region = region_of(fetch_addr, loader_end_pg, program_end_pg);
    rd_region = region_of(read_addr, loader_end_pg, program_end_pg);
    allow = 1'b0;
    halt_needed = 1'b0;
    case (exec_region_r)
      `FSG_REG_LOADER:
      begin
        if (wr_is_eeprom)
          allow = 1'b1;
        else if (wr_region != `FSG_REG_LOADER)
        begin
          allow = 1'b1;
          halt_needed = 1'b1;
        end
      end
      `FSG_REG_PROGRAM:
      begin
        if (wr_is_eeprom)
          allow = 1'b1;
        else if (wr_region == `FSG_REG_PARAM)
        begin
          allow = 1'b1;
          halt_needed = 1'b1;
        end
      end
      default:
        allow = 1'b0;
    endcase
    // Write locks only guard flash regions.
    if (!wr_is_eeprom && wr_region == `FSG_REG_PROGRAM &&
        program_write_lock_r)
      allow = 1'b0;
    if (!wr_is_eeprom && wr_region == `FSG_REG_PARAM &&
        parameter_write_lock_r)
      allow = 1'b0;
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (wr_req && allow && halt_needed)
          state_nxt = ST_HALT;
      ST_HALT:
        if (cnt_r == HALT_LAST)
          state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // Next values; a request is only taken while the guard is idle.
  always @*
  begin
    take_req = (state_r == ST_IDLE) && wr_req;
    flash_grant = take_req && allow && !wr_is_eeprom;
    eeprom_grant = take_req && allow && wr_is_eeprom;
    // A refused write never enters the halt state, so the CPU runs on.
    refuse = take_req && !allow;
    // The counter runs only while halted and restarts from zero.
    if (state_r == ST_HALT)
      cnt_nxt = cnt_r + 8'h01;
    else
      cnt_nxt = {CNT_W{1'b0}};
    // The last valid fetch decides the region of the running code.
    exec_region_nxt = exec_region_r;
    if (fetch_valid)
      exec_region_nxt = fetch_region;
    // With the whole flash as loader the program start wraps to zero.
    if (vector_table_select)
      vector_base_nxt = {ADDR_W{1'b0}};
    else
      vector_base_nxt = {loader_end_pg[PAGE_W-1:0],
                         {`FSG_PAGE_SHIFT{1'b0}}};
    // The lock request is only honoured from the loader region. It bites
    // once the fetches have left that region.
    lock_armed_nxt = lock_armed_r;
    if (loader_read_lock_set && exec_region_r == `FSG_REG_LOADER)
      lock_armed_nxt = 1'b1;
    loader_read_lock_nxt = loader_read_lock_r;
    if (lock_armed_r && exec_region_r != `FSG_REG_LOADER)
      loader_read_lock_nxt = 1'b1;
    // Write locks are sticky until reset.
    program_write_lock_nxt = program_write_lock_r ||
                             program_write_lock_set;
    parameter_write_lock_nxt = parameter_write_lock_r ||
                               parameter_write_lock_set;
    // A locked loader can be neither fetched from nor read.
    fetch_blocked_nxt = loader_read_lock_r && fetch_valid &&
                        fetch_region == `FSG_REG_LOADER;
    read_blocked_nxt = loader_read_lock_r && read_valid &&
                       rd_region == `FSG_REG_LOADER;
  end

  // Halt state machine and the length counter of the stall.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      cnt_r <= {CNT_W{1'b0}};
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Write answers are one-cycle pulses, exactly one per request taken.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      flash_wr_en_r <= 1'b0;
      eeprom_wr_en_r <= 1'b0;
      wr_refused_r <= 1'b0;
    end
    else
    begin
      flash_wr_en_r <= flash_grant;
      eeprom_wr_en_r <= eeprom_grant;
      wr_refused_r <= refuse;
    end
  end

  // The stall rises with the flash grant and stands for the halt count.
  // Requests seen while halted get no answer at all.
  always @(posedge clk)
  begin
    if (!rst_n)
      cpu_halt_r <= 1'b0;
    else
      cpu_halt_r <= (state_nxt == ST_HALT);
  end

  // The granted address is held so the CPU may move on to other work.
  // Only a flash grant updates it; refused and EEPROM writes leave it.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      flash_wr_addr_r <= {ADDR_W{1'b0}};
      flash_wr_len_r <= `FSG_WLEN_BYTE;
    end
    else if (flash_grant)
    begin
      flash_wr_addr_r <= wr_addr;
      flash_wr_len_r <= wr_len;
    end
  end

  // Region of the code now running, and the vector table base.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      exec_region_r <= `FSG_REG_LOADER;
      vector_base_r <= {ADDR_W{1'b0}};
    end
    else
    begin
      exec_region_r <= exec_region_nxt;
      vector_base_r <= vector_base_nxt;
    end
  end

  // Arming is kept apart so the read lock waits for the exit.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      lock_armed_r <= 1'b0;
      loader_read_lock_r <= 1'b0;
    end
    else
    begin
      lock_armed_r <= lock_armed_nxt;
      loader_read_lock_r <= loader_read_lock_nxt;
    end
  end

  // Write locks for the program and parameter regions.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      program_write_lock_r <= 1'b0;
      parameter_write_lock_r <= 1'b0;
    end
    else
    begin
      program_write_lock_r <= program_write_lock_nxt;
      parameter_write_lock_r <= parameter_write_lock_nxt;
    end
  end

  // Read-protect hits flag the access one cycle later.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      fetch_blocked_r <= 1'b0;
      read_blocked_r <= 1'b0;
    end
    else
    begin
      fetch_blocked_r <= fetch_blocked_nxt;
      read_blocked_r <= read_blocked_nxt;
    end
  end
endmodule // fsg_flash_section_write_guard
`default_nettype wire

// ==== hw/fsg_defines.vh ====
`ifndef FSG_DEFINES_VH
`define FSG_DEFINES_VH
// Page size in bytes and its address shift.
`define FSG_PAGE_BYTES 512
`define FSG_PAGE_SHIFT 9
// Region codes.
`define FSG_REG_LOADER 2'h0
`define FSG_REG_PROGRAM 2'h1
`define FSG_REG_PARAM 2'h2
`define FSG_REG_NONE 2'h3
// Default fuse values used when a fuse points beyond the flash end.
`define FSG_LOADER_FUSE_DEFAULT 8'h00
`define FSG_PROGRAM_FUSE_DEFAULT 8'h00
// Write lengths.
`define FSG_WLEN_BYTE 1'b0
`define FSG_WLEN_WORD 1'b1
`endif

// ==== hw/fsg_region_map.v ====
`timescale 1ns/1ps
`default_nettype none
// Registered region boundaries in pages, from the two size fuses.
module fsg_region_map #(
  parameter FUSE_W = 8,
  parameter PAGE_W = 8,
  parameter FLASH_PAGES = 128
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Fuses
  input wire [FUSE_W-1:0] loader_size_fuse,
  input wire [FUSE_W-1:0] program_size_fuse,
  // Boundaries, in pages
  output reg [PAGE_W:0] loader_end_pg_r,
  output reg [PAGE_W:0] program_end_pg_r
);
  localparam [31:0] LAST_I = FLASH_PAGES;
  localparam [PAGE_W:0] LAST = LAST_I[PAGE_W:0];
  reg [FUSE_W-1:0] lf;
  reg [FUSE_W-1:0] pf;
  reg [PAGE_W:0] le_nxt;
  reg [PAGE_W:0] pe_nxt;
  always @*
  begin
    lf = loader_size_fuse;
    pf = program_size_fuse;
    // A boundary past the flash end falls back to the default fuse.
    if ({1'b0, lf} > LAST)
      lf = `FSG_LOADER_FUSE_DEFAULT;
    if ({1'b0, pf} > LAST)
      pf = `FSG_PROGRAM_FUSE_DEFAULT;
    if (lf == 0)
    begin
      le_nxt = LAST;
      pe_nxt = LAST;
    end
    else if (pf == 0)
    begin
      le_nxt = lf;
      pe_nxt = LAST;
    end
    else if (pf <= lf)
    begin
      le_nxt = lf;
      pe_nxt = lf;
    end
    else
    begin
      le_nxt = lf;
      pe_nxt = pf;
    end
  end
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      loader_end_pg_r <= LAST;
      program_end_pg_r <= LAST;
    end
    else
    begin
      loader_end_pg_r <= le_nxt;
      program_end_pg_r <= pe_nxt;
    end
  end
endmodule // fsg_region_map
`default_nettype wire

// ==== tb/fsg_guard_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module fsg_guard_monitor #(
  parameter HALT_CYCLES = 16
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Request and answer
  input wire wr_req,
  input wire [15:0] wr_addr,
  input wire flash_wr_en_r,
  input wire eeprom_wr_en_r,
  input wire wr_refused_r,
  input wire cpu_halt_r,
  input wire [15:0] flash_wr_addr_r,
  input wire [1:0] exec_region_r
);
  wire any_w = flash_wr_en_r | eeprom_wr_en_r | wr_refused_r;
  reg [7:0] halt_cnt_r;
  // A counter checks the stall length, since a long repeat unrolls badly.
  always @(posedge clk)
    halt_cnt_r <= cpu_halt_r ? halt_cnt_r + 8'h01 : 8'h00;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  one_answer_a:
    assert property ($onehot0({flash_wr_en_r, eeprom_wr_en_r, wr_refused_r}))
      else $error("two answers at once");
  answer_next_a:
    assert property (wr_req && !cpu_halt_r |=> any_w)
      else $error("request got no answer");
  answer_cause_a:
    assert property (any_w |-> $past(wr_req) && !$past(cpu_halt_r))
      else $error("answer without request");
  halt_length_a:
    assert property ($fell(cpu_halt_r) |-> halt_cnt_r == HALT_CYCLES)
      else $error("wrong stall length");
  halt_grant_a:
    assert property ($rose(cpu_halt_r) |-> flash_wr_en_r)
      else $error("stall without flash grant");
  refuse_nohalt_a:
    assert property (wr_refused_r |-> !cpu_halt_r)
      else $error("refused write stalls");
  param_exec_a:
    assert property (wr_req && !cpu_halt_r && exec_region_r == 2'h2
      |=> wr_refused_r) else $error("write allowed from data region");
  addr_latch_a:
    assert property (flash_wr_en_r |-> flash_wr_addr_r == $past(wr_addr))
      else $error("granted address not latched");
endmodule // fsg_guard_monitor
`default_nettype wire

// ==== tb/fsg_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module fsg_cpu_model (
  // Clock and stall
  input wire clk,
  input wire cpu_halt_r,
  // Store request
  output logic wr_req,
  output logic [15:0] wr_addr,
  output logic wr_is_eeprom,
  output logic wr_len
);
  initial
  begin
    wr_req = 1'h0;
    wr_addr = 16'h0000;
    wr_is_eeprom = 1'h0;
    wr_len = 1'h0;
  end
  task automatic store(input logic [15:0] a, input logic e, input logic l);
    int n;
    n = 0;
    while (cpu_halt_r !== 1'h0 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    wr_req = 1'h1;
    wr_addr = a;
    wr_is_eeprom = e;
    wr_len = l;
    @(negedge clk);
    wr_req = 1'h0;
    // The released address and EEPROM lines change so a stale value cannot pass for a held one.
    wr_addr = ~a;
    wr_is_eeprom = ~e;
  endtask
endmodule // fsg_cpu_model
`default_nettype wire

// ==== tb/fsg_flash_section_write_guard_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module fsg_flash_section_write_guard_tb;
  localparam HC = 2;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] lf = 8'h04;
  logic [7:0] pf = 8'h08;
  logic [15:0] fa = 16'h0000;
  logic [15:0] ra = 16'h0100;
  logic fv = 1'h1;
  logic rv = 1'h0;
  logic vs = 1'h0;
  logic rl = 1'h0;
  logic pl = 1'h0;
  logic ql = 1'h0;
  wire wr_req, wr_is_eeprom, wr_len, fwe, ewe, rfs, halt, fwl, fb, rb;
  wire llk, plk, qlk;
  wire [15:0] wr_addr, fwa, vb;
  wire [1:0] er;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  logic [35:0] rows [12] = '{
    {16'h0000, 16'h0100, 1'h0, 3'h1}, {16'h0000, 16'h0900, 1'h0, 3'h4},
    {16'h0000, 16'h2002, 1'h0, 3'h4}, {16'h0000, 16'h0000, 1'h1, 3'h2},
    {16'h0900, 16'h0100, 1'h0, 3'h1}, {16'h0900, 16'h0A00, 1'h0, 3'h1},
    {16'h0900, 16'h2000, 1'h0, 3'h4}, {16'h0900, 16'h0000, 1'h1, 3'h2},
    {16'h2000, 16'h0100, 1'h0, 3'h1}, {16'h2000, 16'h0900, 1'h0, 3'h1},
    {16'h2000, 16'h2000, 1'h0, 3'h1}, {16'h2000, 16'h0000, 1'h1, 3'h1}};
  logic [33:0] fz [7] = '{
    {8'h00, 8'h08, 16'h8000, 2'h0}, {8'h04, 8'h00, 16'h8000, 2'h1},
    {8'h04, 8'h03, 16'h0900, 2'h2}, {8'hC8, 8'h08, 16'h8000, 2'h0},
    {8'h04, 8'h08, 16'h07FF, 2'h0}, {8'h04, 8'h08, 16'h1000, 2'h2},
    {8'h04, 8'h08, 16'h0FFF, 2'h1}};
  always #2 clk = ~clk;
  fsg_flash_section_write_guard #(.HALT_CYCLES(HC))
    i_fsg_flash_section_write_guard (.clk(clk), .rst_n(rst_n),
    .loader_size_fuse(lf), .program_size_fuse(pf), .fetch_addr(fa),
    .fetch_valid(fv), .read_addr(ra), .read_valid(rv), .wr_req(wr_req),
    .wr_addr(wr_addr), .wr_is_eeprom(wr_is_eeprom), .wr_len(wr_len),
    .vector_table_select(vs), .loader_read_lock_set(rl),
    .program_write_lock_set(pl), .parameter_write_lock_set(ql),
    .flash_wr_en_r(fwe), .eeprom_wr_en_r(ewe), .wr_refused_r(rfs),
    .cpu_halt_r(halt), .flash_wr_addr_r(fwa), .flash_wr_len_r(fwl),
    .fetch_blocked_r(fb), .read_blocked_r(rb), .exec_region_r(er),
    .vector_base_r(vb), .loader_read_lock_r(llk),
    .program_write_lock_r(plk), .parameter_write_lock_r(qlk));
  fsg_cpu_model i_fsg_cpu_model (.clk(clk), .cpu_halt_r(halt),
    .wr_req(wr_req), .wr_addr(wr_addr), .wr_is_eeprom(wr_is_eeprom),
    .wr_len(wr_len));
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'h1)
    begin
      $display("BAD %0t %s", $time, m);
      fail_count++;
    end
  endtask
  task results;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic e, input logic [2:0] x);
    i_fsg_cpu_model.store(a, e, a[1]);
    chk({fwe, ewe, rfs} === x, "write answer");
    chk(halt === x[2], "stall state");
    if (x[2])
      chk(fwa === a && fwl === a[1], "latched write");
  endtask
  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      fail_count++;
      results;
    end
  end
  initial
  begin
    gap(8);
    rst_n = 1'h1;
    gap(2);
    for (int i = 0; i < 12; i++)
    begin
      fa = rows[i][35:20];
      gap(2);
      wr(rows[i][19:4], rows[i][3], rows[i][2:0]);
    end
    for (int i = 0; i < 7; i++)
    begin
      {lf, pf, fa} = fz[i][33:2];
      gap(3);
      chk(er === fz[i][1:0], "region");
    end
    chk(vb === 16'h0800, "vector base");
    vs = 1'h1;
    gap(2);
    chk(vb === 16'h0000, "vector base moved");
    fa = 16'h0000;
    pl = 1'h1;
    ql = 1'h1;
    gap(1);
    pl = 1'h0;
    ql = 1'h0;
    chk(plk === 1'h1 && qlk === 1'h1, "write locks");
    wr(16'h0900, 1'h0, 3'h1);
    wr(16'h2000, 1'h0, 3'h1);
    wr(16'h0000, 1'h1, 3'h2);
    fa = 16'h0900;
    rv = 1'h1;
    gap(2);
    rl = 1'h1;
    gap(1);
    rl = 1'h0;
    gap(2);
    chk(rb === 1'h0 && llk === 1'h0, "lock set outside loader");
    fa = 16'h0000;
    gap(2);
    rl = 1'h1;
    gap(1);
    rl = 1'h0;
    gap(2);
    chk(rb === 1'h0 && llk === 1'h0, "lock early");
    fa = 16'h0900;
    gap(3);
    chk(rb === 1'h1 && llk === 1'h1, "read not blocked");
    fa = 16'h0100;
    gap(1);
    chk(fb === 1'h1, "fetch not blocked");
    fv = 1'h0;
    fa = 16'h2000;
    gap(2);
    chk(er === 2'h0 && fb === 1'h0, "fetch taken while invalid");
    rst_n = 1'h0;
    gap(2);
    chk({fwe, ewe, rfs, halt, fb, rb, llk, plk, qlk, fwl, er, vb, fwa}
      === 44'h0, "reset values");
    results;
  end
endmodule // fsg_flash_section_write_guard_tb
bind fsg_flash_section_write_guard fsg_guard_monitor
  #(.HALT_CYCLES(HALT_CYCLES)) i_fsg_guard_monitor (.clk(clk),
  .rst_n(rst_n), .wr_req(wr_req), .wr_addr(wr_addr),
  .flash_wr_en_r(flash_wr_en_r), .eeprom_wr_en_r(eeprom_wr_en_r),
  .wr_refused_r(wr_refused_r), .cpu_halt_r(cpu_halt_r),
  .flash_wr_addr_r(flash_wr_addr_r), .exec_region_r(exec_region_r));
`default_nettype wire
